//--- core/irq_arbiter_consts.vh
// constants for the three-level vectored interrupt arbiter
`ifndef IRQ_ARBITER_CONSTS_VH
`define IRQ_ARBITER_CONSTS_VH

`define IRQ_NUM_SRC      35
`define IRQ_NUM_VEC      10
`define IRQ_VEC_W        4
`define IRQ_ADDR_W       17
`define IRQ_VEC_BASE     17'h00003
`define IRQ_VEC_STEP     17'h00008
// level codes, larger wins; idle level sits below low
`define IRQ_LVL_W        2
`define IRQ_LVL_NONE     2'h0
`define IRQ_LVL_LOW      2'h1
`define IRQ_LVL_HIGH     2'h2
`define IRQ_LVL_TOP      2'h3
// vectors allowed to use the highest level
`define IRQ_NUM_TOP_VEC  2
// service stack depth: one entry per level
`define IRQ_STK_DEPTH    3

`endif

//--- core/irq_vec_pick.v
// picks the highest-level, lowest-numbered pending vector above a floor level
`timescale 1ns/1ps
`default_nettype none
`include "irq_arbiter_consts.vh"
module irq_vec_pick (
    input  wire [`IRQ_NUM_VEC-1:0]            pend_i,
    input  wire [`IRQ_NUM_VEC*`IRQ_LVL_W-1:0] lvl_i,
    input  wire [`IRQ_LVL_W-1:0]              floor_i,
    output reg                                hit_o,
    output reg  [`IRQ_VEC_W-1:0]              vec_o,
    output reg  [`IRQ_LVL_W-1:0]              lvl_o
);
    integer k;
    reg [`IRQ_LVL_W-1:0] cur;
    // scan from the top vector down so lower numbers overwrite on ties
    always @* begin
        hit_o = 1'b0;
        vec_o = {`IRQ_VEC_W{1'b0}};
        lvl_o = `IRQ_LVL_NONE;
        cur   = `IRQ_LVL_NONE;
        for (k = `IRQ_NUM_VEC-1; k >= 0; k = k - 1) begin
            cur = lvl_i[k*`IRQ_LVL_W +: `IRQ_LVL_W];
            if (pend_i[k] && (cur > floor_i) && (cur >= lvl_o)) begin
                hit_o = 1'b1;
                vec_o = k[`IRQ_VEC_W-1:0];
                lvl_o = cur;
            end
        end
    end
endmodule // irq_vec_pick
`default_nettype wire

//--- core/irq_arbiter.v
// three-level vectored interrupt arbiter: source merge, pending, nesting
`timescale 1ns/1ps
`default_nettype none
`include "irq_arbiter_consts.vh"
module irq_arbiter (
    input  wire                               core_clk_i,
    input  wire                               rstn_i,
    // source pulses, one cycle each, from on-chip peripherals (same clock)
    input  wire                               ext_irq_a_i,
    input  wire                               ext_irq_b_i,
    input  wire                               ext_irq_c_i,
    input  wire                               ext_irq_d_i,
    input  wire                               ext_irq_e_i,
    input  wire                               ext_irq_f_i,
    input  wire                               ext_irq_g_i,
    input  wire                               ext_irq_h_i,
    input  wire                               capture_timer_low_i,
    input  wire                               capture_timer_high_i,
    input  wire                               pwm_timer_low_i,
    input  wire                               pwm_timer_high_i,
    input  wire                               usb_bus_active_i,
    input  wire                               base_timer_i,
    input  wire                               sync_serial_first_i,
    input  wire                               usb_bus_reset_i,
    input  wire                               usb_suspend_i,
    input  wire                               full_duplex_uart_rx_done_i,
    input  wire                               smartcard_uart_rx_done_i,
    input  wire                               sync_serial_second_i,
    input  wire                               usb_endpoint_i,
    input  wire                               usb_frame_start_i,
    input  wire                               sync_serial_third_i,
    input  wire                               full_duplex_uart_buf_empty_i,
    input  wire                               full_duplex_uart_tx_done_i,
    input  wire                               smartcard_uart_buf_empty_i,
    input  wire                               smartcard_uart_tx_done_i,
    input  wire                               adc_done_i,
    input  wire                               interval_timer_c_i,
    input  wire                               interval_timer_d_i,
    input  wire                               port0_i,
    input  wire                               pwm_ch0_i,
    input  wire                               pwm_ch1_i,
    input  wire                               interval_timer_a_i,
    input  wire                               interval_timer_b_i,
    // per-vector level selection, 2 bits each, vector 0 in the low bits
    input  wire [`IRQ_NUM_VEC*`IRQ_LVL_W-1:0] vec_level_i,
    // core side
    input  wire                               irq_ack_i,
    input  wire                               irq_done_i,
    output wire                               irq_req_o,
    output reg  [`IRQ_ADDR_W-1:0]             irq_addr_o,
    output reg  [`IRQ_LVL_W-1:0]              irq_level_o,
    output wire [`IRQ_LVL_W-1:0]              svc_level_o,
    output wire [`IRQ_NUM_VEC-1:0]            pending_o
);
    // merged source lines per vector
    wire [`IRQ_NUM_VEC-1:0] vec_src;
    assign vec_src[0] = ext_irq_a_i;
    assign vec_src[1] = ext_irq_b_i;
    assign vec_src[2] = ext_irq_c_i | capture_timer_low_i | ext_irq_e_i | usb_bus_active_i;
    assign vec_src[3] = ext_irq_d_i | ext_irq_f_i | base_timer_i;
    assign vec_src[4] = capture_timer_high_i | ext_irq_g_i;
    assign vec_src[5] = pwm_timer_low_i | pwm_timer_high_i | ext_irq_h_i;
    assign vec_src[6] = sync_serial_first_i | usb_bus_reset_i | usb_suspend_i
                      | full_duplex_uart_rx_done_i | smartcard_uart_rx_done_i;
    assign vec_src[7] = sync_serial_second_i | usb_endpoint_i | usb_frame_start_i | sync_serial_third_i
                      | full_duplex_uart_buf_empty_i | full_duplex_uart_tx_done_i
                      | smartcard_uart_buf_empty_i | smartcard_uart_tx_done_i;
    assign vec_src[8] = adc_done_i | interval_timer_c_i | interval_timer_d_i;
    assign vec_src[9] = port0_i | pwm_ch0_i | pwm_ch1_i | interval_timer_a_i | interval_timer_b_i;

    // legalise level choices: top only on the first vectors, else high ceiling
    wire [`IRQ_NUM_VEC*`IRQ_LVL_W-1:0] eff_lvl;
    genvar g;
    generate
        for (g = 0; g < `IRQ_NUM_VEC; g = g + 1) begin : g_lvl
            wire [`IRQ_LVL_W-1:0] req_lvl = vec_level_i[g*`IRQ_LVL_W +: `IRQ_LVL_W];
            if (g < `IRQ_NUM_TOP_VEC) begin : g_top
                // highest or low only; anything but top reads as low
                assign eff_lvl[g*`IRQ_LVL_W +: `IRQ_LVL_W] =
                    (req_lvl == `IRQ_LVL_TOP) ? `IRQ_LVL_TOP : `IRQ_LVL_LOW;
            end else begin : g_hl
                // high or low only; anything but high reads as low
                assign eff_lvl[g*`IRQ_LVL_W +: `IRQ_LVL_W] =
                    (req_lvl == `IRQ_LVL_HIGH) ? `IRQ_LVL_HIGH : `IRQ_LVL_LOW;
            end
        end
    endgenerate

    // service stack of levels; nesting depth bounded by the level count
    reg [`IRQ_LVL_W-1:0] stk_ff [0:`IRQ_STK_DEPTH-1];
    reg [1:0]            sp_ff;
    wire [`IRQ_LVL_W-1:0] svc_lvl = (sp_ff == 2'h0) ? `IRQ_LVL_NONE : stk_ff[sp_ff - 2'h1];
    assign svc_level_o = svc_lvl;

    reg  [`IRQ_NUM_VEC-1:0] pend_ff;
    reg                     req_ff;
    wire                    hit;
    wire [`IRQ_VEC_W-1:0]   win_vec;
    wire [`IRQ_LVL_W-1:0]   win_lvl;

    irq_vec_pick u_pick (
        .pend_i  (pend_ff),
        .lvl_i   (eff_lvl),
        .floor_i (svc_lvl),
        .hit_o   (hit),
        .vec_o   (win_vec),
        .lvl_o   (win_lvl)
    );

    assign irq_req_o = req_ff;
    assign pending_o = pend_ff;

    // offered vector index latched with the request
    reg [`IRQ_VEC_W-1:0] req_vec_ff;
    wire take = req_ff & irq_ack_i;
    wire pop  = irq_done_i & (sp_ff != 2'h0) & ~take;

    // pending flags: new event wins over the clear by acceptance
    integer i;
    reg [`IRQ_NUM_VEC-1:0] nxt_pend;
    always @* begin
        nxt_pend = pend_ff;
        for (i = 0; i < `IRQ_NUM_VEC; i = i + 1) begin
            if (take && (req_vec_ff == i[`IRQ_VEC_W-1:0])) begin
                nxt_pend[i] = 1'b0;
            end
            if (vec_src[i]) begin
                nxt_pend[i] = 1'b1;
            end
        end
    end

    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_ff <= {`IRQ_NUM_VEC{1'b0}};
        end else begin
            pend_ff <= nxt_pend;
        end
    end

    // request offer: re-evaluated every cycle, dropped while being taken
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_ff      <= 1'b0;
            req_vec_ff  <= {`IRQ_VEC_W{1'b0}};
            irq_addr_o  <= {`IRQ_ADDR_W{1'b0}};
            irq_level_o <= `IRQ_LVL_NONE;
        end else begin
            // blocked vectors simply stay pending until the floor drops
            req_ff     <= hit & ~take & ~pop;
            req_vec_ff <= win_vec;
            irq_addr_o <= `IRQ_VEC_BASE + `IRQ_VEC_STEP * {{(`IRQ_ADDR_W-`IRQ_VEC_W){1'b0}}, win_vec};
            irq_level_o <= win_lvl;
        end
    end

    // stack push on acceptance, pop on completion
    integer j;
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sp_ff <= 2'h0;
            for (j = 0; j < `IRQ_STK_DEPTH; j = j + 1) begin
                stk_ff[j] <= `IRQ_LVL_NONE;
            end
        end else if (take && (sp_ff < `IRQ_STK_DEPTH)) begin
            stk_ff[sp_ff] <= irq_level_o;
            sp_ff         <= sp_ff + 2'h1;
        end else if (pop) begin
            sp_ff <= sp_ff - 2'h1;
        end
    end
endmodule // irq_arbiter
`default_nettype wire

//--- tb/irq_arbiter_props.sv
// checker for the interrupt arbiter ports
`timescale 1ns/1ps
`default_nettype none
module irq_arbiter_props (
    input wire logic        core_clk_i, rstn_i, irq_ack_i, irq_req_o,
    input wire logic        ext_irq_a_i, sync_serial_first_i, usb_endpoint_i,
    input wire logic [16:0] irq_addr_o,
    input wire logic [1:0]  irq_level_o, svc_level_o,
    input wire logic [9:0]  pending_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    a_event_pends: assert property (ext_irq_a_i |=> pending_o[0]) else $error("event lost");
    a_serial_route: assert property (sync_serial_first_i |=> pending_o[6]) else $error("bad route");
    a_endpoint_route: assert property (usb_endpoint_i |=> pending_o[7]) else $error("bad route");
    a_addr_legal: assert property (irq_req_o |-> irq_addr_o[2:0] == 3'h3 && irq_addr_o <= 17'h0004B)
        else $error("bad address");
    a_top_first_two: assert property (irq_req_o && irq_level_o == 2'h3 |-> irq_addr_o <= 17'h0000B)
        else $error("top level misused");
    a_level_above: assert property (irq_req_o |-> irq_level_o > svc_level_o) else $error("not above");
    a_ack_nests: assert property (irq_req_o && irq_ack_i |=> !irq_req_o && svc_level_o == $past(irq_level_o))
        else $error("no nesting");
    a_pend_kept: assert property (!(irq_req_o && irq_ack_i) |=> (pending_o & $past(pending_o)) == $past(pending_o))
        else $error("pending lost");
    c_taken: cover property (irq_req_o && irq_ack_i);
    c_top: cover property (irq_req_o && irq_level_o == 2'h3);
    c_blocked: cover property (!irq_req_o && pending_o != 10'h000 && svc_level_o != 2'h0);
    c_deep: cover property (svc_level_o == 2'h3 && pending_o == 10'h000);
endmodule // irq_arbiter_props
bind irq_arbiter irq_arbiter_props u_props (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .irq_ack_i(irq_ack_i),
    .irq_req_o(irq_req_o), .ext_irq_a_i(ext_irq_a_i), .sync_serial_first_i(sync_serial_first_i),
    .usb_endpoint_i(usb_endpoint_i), .irq_addr_o(irq_addr_o), .irq_level_o(irq_level_o),
    .svc_level_o(svc_level_o), .pending_o(pending_o));
`default_nettype wire

//--- tb/core_model.sv
// processor core stand-in: takes offers, returns from service on command
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic core_clk_i,
    input  wire logic rstn_i,
    input  wire logic accept_en_i,
    input  wire logic finish_i,
    input  wire logic irq_req_i,
    output var  logic irq_ack_o,
    output var  logic irq_done_o
);
    // ack only while offered, one pulse per offer; done follows finish with no check against an ack
    always @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_ack_o  <= 1'b0;
            irq_done_o <= 1'b0;
        end else begin
            irq_ack_o  <= accept_en_i & irq_req_i & ~irq_ack_o;
            irq_done_o <= finish_i & ~irq_done_o;
        end
    end
endmodule // core_model
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, rstn = 1'b0, accept_en = 1'b0, finish = 1'b0, ack, done, req;
    logic [34:0] src = '0;
    logic [19:0] lvl = '0;
    logic [16:0] addr;
    logic [1:0]  level, svc;
    logic [9:0]  pend;
    int          mismatches = 0, cmp_count = 0;
    int          per_vec [10] = '{1, 1, 4, 3, 2, 3, 5, 8, 3, 5}; // sources per vector, vector order
    always #2 clk = ~clk;
    irq_arbiter dut (.core_clk_i(clk), .rstn_i(rstn), .ext_irq_a_i(src[0]), .ext_irq_b_i(src[1]),
        .ext_irq_c_i(src[2]), .capture_timer_low_i(src[3]), .ext_irq_e_i(src[4]), .usb_bus_active_i(src[5]),
        .ext_irq_d_i(src[6]), .ext_irq_f_i(src[7]), .base_timer_i(src[8]), .capture_timer_high_i(src[9]),
        .ext_irq_g_i(src[10]), .pwm_timer_low_i(src[11]), .pwm_timer_high_i(src[12]), .ext_irq_h_i(src[13]),
        .sync_serial_first_i(src[14]), .usb_bus_reset_i(src[15]), .usb_suspend_i(src[16]),
        .full_duplex_uart_rx_done_i(src[17]), .smartcard_uart_rx_done_i(src[18]), .sync_serial_second_i(src[19]),
        .usb_endpoint_i(src[20]), .usb_frame_start_i(src[21]), .sync_serial_third_i(src[22]),
        .full_duplex_uart_buf_empty_i(src[23]), .full_duplex_uart_tx_done_i(src[24]),
        .smartcard_uart_buf_empty_i(src[25]), .smartcard_uart_tx_done_i(src[26]), .adc_done_i(src[27]),
        .interval_timer_c_i(src[28]), .interval_timer_d_i(src[29]), .port0_i(src[30]), .pwm_ch0_i(src[31]),
        .pwm_ch1_i(src[32]), .interval_timer_a_i(src[33]), .interval_timer_b_i(src[34]), .vec_level_i(lvl),
        .irq_ack_i(ack), .irq_done_i(done), .irq_req_o(req), .irq_addr_o(addr), .irq_level_o(level),
        .svc_level_o(svc), .pending_o(pend));
    core_model partner (.core_clk_i(clk), .rstn_i(rstn), .accept_en_i(accept_en), .finish_i(finish),
        .irq_req_i(req), .irq_ack_o(ack), .irq_done_o(done));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [16:0] seen, exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // wait for the offer bounded, check it, let the core take it
    task automatic serve(input int v, input logic [1:0] l);
        for (int i = 0; i < 20 && req !== 1'b1; i++) tick();
        chk(addr, 17'h00003 + 17'(8 * v), "addr");
        chk(level, l, "level");
        accept_en = 1'b1;
        tick(3);
        accept_en = 1'b0;
        chk(svc, l, "svc");
        chk(pend[v], 1'b0, "pend taken");
    endtask
    task automatic finish_svc(input logic [1:0] l);
        finish = 1'b1;
        tick();
        finish = 1'b0;
        tick(2);
        chk(svc, l, "svc after done");
    endtask
    task automatic t_routing;
        int s = 0;
        lvl = 20'hAAAAA;
        for (int v = 0; v < 10; v++)
            for (int k = 0; k < per_vec[v]; k++) begin
                src[s] = 1'b1;
                tick();
                src[s] = 1'b0;
                s++;
                serve(v, v < 2 ? 2'h1 : 2'h2);
                finish_svc(2'h0);
            end
    endtask
    // three at once: v0 low, v2 and v5 high; then v0 raised to top
    task automatic t_precedence;
        lvl = 20'hAAAA9;
        src = 35'h00000805;
        tick();
        src = '0;
        tick(3);
        chk(addr, 17'h00013, "tie");
        lvl = 20'hAAAAB;
        tick(3);
        serve(0, 2'h3);
        chk(req, 1'b0, "blocked");
        finish_svc(2'h0);
        serve(2, 2'h2);
        finish_svc(2'h0);
        serve(5, 2'h2);
        finish_svc(2'h0);
    endtask
    task automatic t_nesting;
        lvl = 20'hAAAA9;
        src[6] = 1'b1;
        tick();
        src = 35'h00000201;
        tick();
        src = '0;
        serve(3, 2'h2);
        tick(4);
        chk(req, 1'b0, "equal refused");
        chk(pend, 10'h011, "kept");
        finish_svc(2'h0);
        serve(4, 2'h2);
        finish_svc(2'h0);
        serve(0, 2'h1);
        src[19] = 1'b1;
        tick();
        src[19] = 1'b0;
        serve(7, 2'h2);
        finish_svc(2'h1);
        finish_svc(2'h0);
    endtask
    // three deep: low, high, top; then done on an empty stack; then event on the take edge
    task automatic t_corner;
        lvl = 20'hAAAA7;
        src[1] = 1'b1;
        tick();
        src[1] = 1'b0;
        serve(1, 2'h1);
        src[2] = 1'b1;
        tick();
        src[2] = 1'b0;
        serve(2, 2'h2);
        src[0] = 1'b1;
        tick();
        src[0] = 1'b0;
        serve(0, 2'h3);
        finish_svc(2'h2);
        finish_svc(2'h1);
        finish_svc(2'h0);
        finish_svc(2'h0);
        chk(req, 1'b0, "idle after spare done");
        src[2] = 1'b1;
        tick();
        src[2] = 1'b0;
        tick();
        chk(req, 1'b1, "offer");
        accept_en = 1'b1;
        tick();
        src[2] = 1'b1;
        tick();
        src[2] = 1'b0;
        accept_en = 1'b0;
        tick();
        chk(pend[2], 1'b1, "event beats take");
        chk(svc, 2'h2, "svc on take");
        finish_svc(2'h0);
        serve(2, 2'h2);
        finish_svc(2'h0);
    endtask
    task automatic wrap_up;
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        tick(20);
        rstn = 1'b1;
        tick(2);
        t_routing();
        t_precedence();
        t_nesting();
        t_corner();
        wrap_up();
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #40000;
        mismatches++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
